// ===== hdl/eior_regs.svh
// register map, field widths and timing constants of the signal router
// assumes a 100 MHz clock and a 32-bit APB register port
// Notes on behaviour
// - each coax terminal carries one signal
// - connector carries several signals, one per pin
// - coax and connector routing held independently
// - coax input goes to trigger, sweep or control
// - control input picks interlock, relay or zero
// - coax trigger output picks one of five events
// - coax sweep output picks one of three events
// - coax control output picks one of four states
// - pin five controls relay or zero
// - pin six drives one trigger event
// - pin seven drives one sweep event
// - pin eight drives one control level
// - output events are 10 us low pulses
// - trigger falling edge starts a measure cycle
// - interlock low forces and keeps source off
// - relay input rise turns on, fall off
// - zero input fall zeroes, rise restores output
`ifndef EIOR_REGS_SVH
`define EIOR_REGS_SVH
`define EIOR_ADDR_W 8
`define EIOR_ADDR_ROUTE 8'h00
`define EIOR_ADDR_CMD 8'h04
`define EIOR_ADDR_STATUS 8'h08
`define EIOR_ROUTE_W 21
`define EIOR_ROUTE_RESET 21'h000000
`define EIOR_CMD_W 6
`define EIOR_STATUS_W 8
`define EIOR_DATA_ZERO 32'h00000000
`define EIOR_PULSE_US 10
`define EIOR_CLK_MHZ 100
`define EIOR_PULSE_CYCLES (`EIOR_PULSE_US * `EIOR_CLK_MHZ)
`define EIOR_CNT_W 10
`define EIOR_IDLE 1'b1
`define EIOR_NUM_IN 5
`define EIOR_IN_COAX 0
`define EIOR_IN_TRIG 1
`define EIOR_IN_SWEEP 2
`define EIOR_IN_LOCK 3
`define EIOR_IN_PIN5 4
`define EIOR_NUM_EV 9
`define EIOR_EV_SWEEP_BASE 5
`define EIOR_EV_PROG 8
`endif

// ===== hdl/eior_pkg.sv
// types of the signal router: selections, command and status layouts
// assumes eior_regs.svh for widths
`include "eior_regs.svh"
package eior_pkg;
  typedef enum logic [1:0] {
    EIOR_IN_CYCLE = 2'b00, EIOR_IN_LAUNCH = 2'b01, EIOR_IN_CTRL = 2'b10
  } eior_in_sel_t;
  typedef enum logic [1:0] {
    EIOR_CTL_LOCK = 2'b00, EIOR_CTL_RELAY = 2'b01, EIOR_CTL_ZERO = 2'b10
  } eior_ctl_t;
  typedef enum logic [1:0] {
    EIOR_OUT_CYCLE = 2'b00, EIOR_OUT_SWEEP = 2'b01, EIOR_OUT_CTRL = 2'b10
  } eior_out_sel_t;
  typedef enum logic [2:0] {
    EIOR_TRG_ORIGIN = 3'h0, EIOR_TRG_SRCCHANGE = 3'h1, EIOR_TRG_MEASBEGIN = 3'h2,
    EIOR_TRG_MEASDONE = 3'h3, EIOR_TRG_PULSEFALL = 3'h4
  } eior_trg_t;
  typedef enum logic [1:0] {
    EIOR_SWP_ORIGIN = 2'b00, EIOR_SWP_PASSDONE = 2'b01, EIOR_SWP_ALLDONE = 2'b10
  } eior_swp_t;
  typedef enum logic [1:0] {
    EIOR_CST_LOCK = 2'b00, EIOR_CST_RELAY = 2'b01, EIOR_CST_ZERO = 2'b10,
    EIOR_CST_PROG = 2'b11
  } eior_cst_t;
  typedef enum logic {EIOR_P5_RELAY = 1'b0, EIOR_P5_ZERO = 1'b1} eior_p5_t;
  typedef struct packed {
    eior_swp_t connectorPinEightSelectHi;
    eior_swp_t connectorPinSevenSelect;
    eior_trg_t connectorPinSixSelect;
    eior_p5_t connectorPinFiveSelect;
    eior_cst_t coaxCtrlType;
    eior_swp_t coaxSweepType;
    eior_trg_t coaxTrigType;
    eior_out_sel_t coaxOutSel;
    eior_ctl_t coaxCtrlIn;
    eior_in_sel_t coaxInSel;
  } eior_route_t;
  typedef struct packed {
    logic zeroOff;
    logic zeroOn;
    logic outOff;
    logic outOn;
    logic progPulse;
    logic progLevel;
  } eior_cmd_t;
  typedef struct packed {
    logic [`EIOR_NUM_IN-1:0] inLevel;
    logic interlockOk;
    logic zeroOn;
    logic sourceOn;
  } eior_status_t;
  typedef struct packed {
    logic cycleOriginEvent;
    logic sourceChangeEvent;
    logic measureBeginEvent;
    logic measureDoneEvent;
    logic pulseFallEvent;
    logic sweepOriginEvent;
    logic repeatPassDoneEvent;
    logic sweepAllDoneEvent;
  } eior_events_t;
endpackage

// ===== hdl/eior_sync_edge.sv
// two-stage synchronisers with edge detection for outside inputs
// assumes raw inputs are asynchronous and idle high
`timescale 1ns/100ps
`include "eior_regs.svh"
module eior_sync_edge #(
  parameter int N = `EIOR_NUM_IN
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  typedef struct packed {
    logic [N-1:0] stage1;
    logic [N-1:0] stage2;
    logic [N-1:0] prev;
  } eior_sync_state_t;
  eior_sync_state_t s;
  eior_sync_state_t next_s;

  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.stage1 = raw;
      next_s.stage2 = s.stage1;
      next_s.prev = s.stage2;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.stage2;
  assign rise = s.stage2 & ~s.prev;
  assign fall = ~s.stage2 & s.prev;

  for (genvar i = 0; i < N; i++) begin : g_chk
    property p_sync_rise;
      @(posedge clk) disable iff (!rst_b)
        (ce && raw[i] && !level[i]) ##1 (ce && raw[i]) |=> level[i];
    endproperty
    a_sync_rise: assert property (p_sync_rise)
      else $error("synchronised level missed a rise");
  end
endmodule // eior_sync_edge

// ===== hdl/eior_pulse_gen.sv
// active-low pulse stretcher: one fire pulse gives a fixed low width
// assumes fire is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`include "eior_regs.svh"
module eior_pulse_gen #(
  parameter int CNT_W = `EIOR_CNT_W,
  parameter logic [CNT_W-1:0] CYCLES = CNT_W'(`EIOR_PULSE_CYCLES)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic fire,
  output logic pulseN
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic outN;
  } eior_pulse_state_t;
  eior_pulse_state_t s;
  eior_pulse_state_t next_s;

  always_comb begin
    next_s = s;
    if (ce) begin
      if (fire) begin
        next_s.outN = 1'b0;
        next_s.count = CYCLES - CNT_W'(1);
      end else if (s.count != '0) begin
        next_s.count = s.count - CNT_W'(1);
      end else begin
        next_s.outN = `EIOR_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{count: '0, outN: `EIOR_IDLE};
    end else begin
      s <= next_s;
    end
  end

  assign pulseN = s.outN;

  sequence s_fire;
    ce && fire;
  endsequence
  sequence s_low_run;
    (!pulseN)[*8];
  endsequence
  property p_pulse_low;
    @(posedge clk) disable iff (!rst_b)
      s_fire |=> (s.count == CYCLES - CNT_W'(1)) ##0 s_low_run;
  endproperty
  a_pulse_low: assert property (p_pulse_low)
    else $error("output pulse not started at full width");
  property p_pulse_end;
    @(posedge clk) disable iff (!rst_b)
      (ce && !fire && !pulseN && s.count == '0) |=> pulseN;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("output pulse did not return high");
endmodule // eior_pulse_gen

// ===== hdl/eior_router.sv
// routes timing and control signals between the instrument core and
// the rear coax terminals and the external connector pins 2 to 9
// assumes APB master on clk, instrument events as one-cycle pulses
`timescale 1ns/100ps
`include "eior_regs.svh"
module eior_router #(
  parameter int ADDR_W = `EIOR_ADDR_W,
  parameter int CNT_W = `EIOR_CNT_W,
  parameter logic [CNT_W-1:0] PULSE_CYCLES = CNT_W'(`EIOR_PULSE_CYCLES)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coaxIn,
  input wire logic connCycleStartInput,
  input wire logic connSweepLaunchInput,
  input wire logic connInterlockInput,
  input wire logic connPinFiveInput,
  input wire eior_pkg::eior_events_t instEvents,
  output logic coaxOut,
  output logic connCycleTimingOutput,
  output logic connSweepTimingOutput,
  output logic connControlStateOutput,
  output logic connProgOutput,
  output logic cycleTrigger,
  output logic sweepLaunch,
  output logic sourceOn,
  output logic zeroOn
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    eior_pkg::eior_route_t route;
    logic progLevel;
    logic progPulse;
    logic srcOn;
    logic zero;
    logic cycTrig;
    logic swpLaunch;
    logic coax;
    logic pinSix;
    logic pinSeven;
    logic pinEight;
    logic pinNine;
  } eior_router_state_t;
  eior_router_state_t s;
  eior_router_state_t next_s;

  logic [`EIOR_NUM_IN-1:0] inRaw;
  logic [`EIOR_NUM_IN-1:0] inLevel;
  logic [`EIOR_NUM_IN-1:0] inRise;
  logic [`EIOR_NUM_IN-1:0] inFall;
  logic [`EIOR_NUM_EV-1:0] evFire;
  logic [`EIOR_NUM_EV-1:0] evPulseN;
  logic coaxIsCtrl;
  logic interlockOk;
  logic relayOnReq;
  logic relayOffReq;
  logic zeroEnterReq;
  logic zeroLeaveReq;
  logic writeAcc;
  logic setupRead;
  logic addrHit;
  eior_pkg::eior_cmd_t cmd;
  eior_pkg::eior_status_t status;

  assign inRaw[`EIOR_IN_COAX] = coaxIn;
  assign inRaw[`EIOR_IN_TRIG] = connCycleStartInput;
  assign inRaw[`EIOR_IN_SWEEP] = connSweepLaunchInput;
  assign inRaw[`EIOR_IN_LOCK] = connInterlockInput;
  assign inRaw[`EIOR_IN_PIN5] = connPinFiveInput;

  eior_sync_edge #(
    .N(`EIOR_NUM_IN)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .raw(inRaw),
    .level(inLevel),
    .rise(inRise),
    .fall(inFall)
  );

  // event order: trigger group, sweep group, programmable
  assign evFire = {s.progPulse, instEvents.sweepAllDoneEvent,
                   instEvents.repeatPassDoneEvent, instEvents.sweepOriginEvent,
                   instEvents.pulseFallEvent, instEvents.measureDoneEvent,
                   instEvents.measureBeginEvent, instEvents.sourceChangeEvent,
                   instEvents.cycleOriginEvent};

  for (genvar i = 0; i < `EIOR_NUM_EV; i++) begin : g_pulse
    eior_pulse_gen #(
      .CNT_W(CNT_W),
      .CYCLES(PULSE_CYCLES)
    ) u_pulse (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .fire(evFire[i]),
      .pulseN(evPulseN[i])
    );
  end

  function automatic logic trigPick(input eior_pkg::eior_trg_t t,
                                    input logic [`EIOR_NUM_EV-1:0] p);
    logic v;
    v = `EIOR_IDLE;
    unique case (t)
      eior_pkg::EIOR_TRG_ORIGIN,
      eior_pkg::EIOR_TRG_SRCCHANGE,
      eior_pkg::EIOR_TRG_MEASBEGIN,
      eior_pkg::EIOR_TRG_MEASDONE,
      eior_pkg::EIOR_TRG_PULSEFALL: v = p[t];
      default: v = `EIOR_IDLE;
    endcase
    return v;
  endfunction

  function automatic logic sweepPick(input eior_pkg::eior_swp_t t,
                                     input logic [`EIOR_NUM_EV-1:0] p);
    logic v;
    v = `EIOR_IDLE;
    unique case (t)
      eior_pkg::EIOR_SWP_ORIGIN,
      eior_pkg::EIOR_SWP_PASSDONE,
      eior_pkg::EIOR_SWP_ALLDONE: v = p[`EIOR_EV_SWEEP_BASE + t];
      default: v = `EIOR_IDLE;
    endcase
    return v;
  endfunction

  // control levels are low when active
  function automatic logic ctrlPick(input eior_pkg::eior_cst_t t, input logic lockOk,
                                    input logic on, input logic zr, input logic prog);
    logic v;
    v = `EIOR_IDLE;
    unique case (t)
      eior_pkg::EIOR_CST_LOCK: v = lockOk;
      eior_pkg::EIOR_CST_RELAY: v = ~on;
      eior_pkg::EIOR_CST_ZERO: v = ~zr;
      eior_pkg::EIOR_CST_PROG: v = prog;
    endcase
    return v;
  endfunction

  assign coaxIsCtrl = (s.route.coaxInSel == eior_pkg::EIOR_IN_CTRL);
  assign interlockOk = inLevel[`EIOR_IN_LOCK] &&
                       !(coaxIsCtrl && s.route.coaxCtrlIn == eior_pkg::EIOR_CTL_LOCK &&
                         !inLevel[`EIOR_IN_COAX]);

  assign writeAcc = psel && penable && pwrite && pready;
  assign setupRead = psel && !penable;
  assign addrHit = (paddr == `EIOR_ADDR_ROUTE) || (paddr == `EIOR_ADDR_CMD) ||
                   (paddr == `EIOR_ADDR_STATUS);
  assign cmd = (writeAcc && paddr == `EIOR_ADDR_CMD) ?
               eior_pkg::eior_cmd_t'(pwdata[`EIOR_CMD_W-1:0]) : '0;

  assign relayOnReq = cmd.outOn ||
    (coaxIsCtrl && s.route.coaxCtrlIn == eior_pkg::EIOR_CTL_RELAY && inRise[`EIOR_IN_COAX]) ||
    (s.route.connectorPinFiveSelect == eior_pkg::EIOR_P5_RELAY &&
     inRise[`EIOR_IN_PIN5]);
  assign relayOffReq = cmd.outOff ||
    (coaxIsCtrl && s.route.coaxCtrlIn == eior_pkg::EIOR_CTL_RELAY && inFall[`EIOR_IN_COAX]) ||
    (s.route.connectorPinFiveSelect == eior_pkg::EIOR_P5_RELAY &&
     inFall[`EIOR_IN_PIN5]);
  assign zeroEnterReq = cmd.zeroOn ||
    (coaxIsCtrl && s.route.coaxCtrlIn == eior_pkg::EIOR_CTL_ZERO && inFall[`EIOR_IN_COAX]) ||
    (s.route.connectorPinFiveSelect == eior_pkg::EIOR_P5_ZERO &&
     inFall[`EIOR_IN_PIN5]);
  assign zeroLeaveReq = cmd.zeroOff ||
    (coaxIsCtrl && s.route.coaxCtrlIn == eior_pkg::EIOR_CTL_ZERO && inRise[`EIOR_IN_COAX]) ||
    (s.route.connectorPinFiveSelect == eior_pkg::EIOR_P5_ZERO &&
     inRise[`EIOR_IN_PIN5]);

  assign status = '{inLevel: inLevel, interlockOk: interlockOk,
                    zeroOn: s.zero, sourceOn: s.srcOn};

  always_comb begin
    next_s = s;
    if (ce) begin
      // register port
      next_s.ready = 1'b1;
      next_s.progPulse = cmd.progPulse;
      if (setupRead) begin
        next_s.slverr = !addrHit;
        next_s.rdata = `EIOR_DATA_ZERO;
        if (!pwrite && paddr == `EIOR_ADDR_ROUTE) begin
          next_s.rdata[`EIOR_ROUTE_W-1:0] = s.route;
        end
        if (!pwrite && paddr == `EIOR_ADDR_CMD) begin
          next_s.rdata[0] = s.progLevel;
        end
        if (!pwrite && paddr == `EIOR_ADDR_STATUS) begin
          next_s.rdata[`EIOR_STATUS_W-1:0] = status;
        end
      end
      if (writeAcc && paddr == `EIOR_ADDR_ROUTE) begin
        next_s.route = eior_pkg::eior_route_t'(pwdata[`EIOR_ROUTE_W-1:0]);
      end
      if (writeAcc && paddr == `EIOR_ADDR_CMD) begin
        next_s.progLevel = cmd.progLevel;
      end
      // input steering
      next_s.cycTrig = inFall[`EIOR_IN_TRIG] ||
        (s.route.coaxInSel == eior_pkg::EIOR_IN_CYCLE && inFall[`EIOR_IN_COAX]);
      next_s.swpLaunch = inFall[`EIOR_IN_SWEEP] ||
        (s.route.coaxInSel == eior_pkg::EIOR_IN_LAUNCH && inFall[`EIOR_IN_COAX]);
      // source state, interlock first, off beats on
      if (!interlockOk) begin
        next_s.srcOn = 1'b0;
      end else if (relayOffReq) begin
        next_s.srcOn = 1'b0;
      end else if (relayOnReq) begin
        next_s.srcOn = 1'b1;
      end
      if (!next_s.srcOn) begin
        next_s.zero = 1'b0;
      end else if (s.srcOn && zeroEnterReq) begin
        next_s.zero = 1'b1;
      end else if (zeroLeaveReq) begin
        next_s.zero = 1'b0;
      end
      // output steering, one source per coax terminal
      unique case (s.route.coaxOutSel)
        eior_pkg::EIOR_OUT_CYCLE: next_s.coax = trigPick(s.route.coaxTrigType, evPulseN);
        eior_pkg::EIOR_OUT_SWEEP: next_s.coax = sweepPick(s.route.coaxSweepType, evPulseN);
        eior_pkg::EIOR_OUT_CTRL: next_s.coax = ctrlPick(s.route.coaxCtrlType, interlockOk,
                                 s.srcOn, s.zero, s.progLevel && evPulseN[`EIOR_EV_PROG]);
        default: next_s.coax = `EIOR_IDLE;
      endcase
      // connector pins, each with its own source
      next_s.pinSix = trigPick(s.route.connectorPinSixSelect, evPulseN);
      next_s.pinSeven = sweepPick(s.route.connectorPinSevenSelect, evPulseN);
      next_s.pinEight = (s.route.connectorPinEightSelectHi == eior_pkg::EIOR_SWP_ALLDONE) ?
        ctrlPick(eior_pkg::EIOR_CST_ZERO, interlockOk, s.srcOn, s.zero, `EIOR_IDLE) :
        ctrlPick(eior_pkg::eior_cst_t'(s.route.connectorPinEightSelectHi), interlockOk,
                 s.srcOn, s.zero, `EIOR_IDLE);
      next_s.pinNine = s.progLevel && evPulseN[`EIOR_EV_PROG];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{rdata: `EIOR_DATA_ZERO, ready: 1'b0, slverr: 1'b0,
             route: eior_pkg::eior_route_t'(`EIOR_ROUTE_RESET), progLevel: `EIOR_IDLE,
             progPulse: 1'b0, srcOn: 1'b0, zero: 1'b0, cycTrig: 1'b0, swpLaunch: 1'b0,
             coax: `EIOR_IDLE, pinSix: `EIOR_IDLE, pinSeven: `EIOR_IDLE,
             pinEight: `EIOR_IDLE, pinNine: `EIOR_IDLE};
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign coaxOut = s.coax;
  assign connCycleTimingOutput = s.pinSix;
  assign connSweepTimingOutput = s.pinSeven;
  assign connControlStateOutput = s.pinEight;
  assign connProgOutput = s.pinNine;
  assign cycleTrigger = s.cycTrig;
  assign sweepLaunch = s.swpLaunch;
  assign sourceOn = s.srcOn;
  assign zeroOn = s.zero;

  property p_interlock_off;
    @(posedge clk) disable iff (!rst_b) (ce && !interlockOk) |=> !sourceOn;
  endproperty
  a_interlock_off: assert property (p_interlock_off)
    else $error("source stayed on with interlock low");

  property p_relay_on;
    @(posedge clk) disable iff (!rst_b)
      (ce && interlockOk && !relayOffReq && inRise[`EIOR_IN_PIN5] &&
       s.route.connectorPinFiveSelect == eior_pkg::EIOR_P5_RELAY) |=> sourceOn;
  endproperty
  a_relay_on: assert property (p_relay_on)
    else $error("relay rising edge did not turn source on");

  property p_trig_start;
    @(posedge clk) disable iff (!rst_b) (ce && inFall[`EIOR_IN_TRIG]) |=> cycleTrigger;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger falling edge did not start a cycle");

  property p_coax_steer;
    @(posedge clk) disable iff (!rst_b)
      (ce && inFall[`EIOR_IN_COAX] && !inFall[`EIOR_IN_TRIG] && !inFall[`EIOR_IN_SWEEP] &&
       s.route.coaxInSel == eior_pkg::EIOR_IN_LAUNCH) |=> (sweepLaunch && !cycleTrigger);
  endproperty
  a_coax_steer: assert property (p_coax_steer)
    else $error("coax input reached the wrong destination");

  property p_zero_enter;
    @(posedge clk) disable iff (!rst_b)
      (ce && sourceOn && interlockOk && !relayOffReq && inFall[`EIOR_IN_PIN5] &&
       s.route.connectorPinFiveSelect == eior_pkg::EIOR_P5_ZERO) |=> zeroOn;
  endproperty
  a_zero_enter: assert property (p_zero_enter)
    else $error("zero input falling edge did not zero output");

  property p_pin8_relay;
    @(posedge clk) disable iff (!rst_b)
      (ce && s.route.connectorPinEightSelectHi == eior_pkg::EIOR_SWP_PASSDONE)
        |=> (connControlStateOutput == !$past(sourceOn));
  endproperty
  a_pin8_relay: assert property (p_pin8_relay)
    else $error("pin eight does not show relay status");

  property p_coax_idle;
    @(posedge clk) disable iff (!rst_b)
      (ce && s.route.coaxOutSel == eior_pkg::EIOR_OUT_CYCLE && (&evPulseN)) |=> coaxOut;
  endproperty
  a_coax_idle: assert property (p_coax_idle)
    else $error("coax output low with no event pulse");

  sequence s_origin_fire;
    ce && instEvents.cycleOriginEvent && s.route.connectorPinSixSelect ==
      eior_pkg::EIOR_TRG_ORIGIN && ce;
  endsequence
  property p_pin6_pulse;
    @(posedge clk) disable iff (!rst_b)
      s_origin_fire ##1 ce |=> !connCycleTimingOutput;
  endproperty
  a_pin6_pulse: assert property (p_pin6_pulse)
    else $error("pin six missed the cycle origin pulse");

  property p_prog_level;
    @(posedge clk) disable iff (!rst_b)
      (ce && s.route.coaxOutSel == eior_pkg::EIOR_OUT_CTRL &&
       s.route.coaxCtrlType == eior_pkg::EIOR_CST_PROG && !s.progLevel) |=> !coaxOut;
  endproperty
  a_prog_level: assert property (p_prog_level)
    else $error("coax output does not follow the programmable level");
endmodule // eior_router

// ===== bench/eior_ext_equip.sv
// outside equipment model driving the router's five input pins
// assumes pins idle high and are sampled by the router on clk
`timescale 1ns/100ps
module eior_ext_equip #(
  parameter int W = 1000
) (
  input wire logic clk,
  output logic [4:0] pins
);
  initial pins = 5'h1F;
  // each level held at least W cycles
  task automatic setPin(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
    repeat (W) @(posedge clk);
  endtask
  // low pulse then back to idle
  task automatic pulse(input int i);
    setPin(i, 1'b0);
    setPin(i, 1'b1);
  endtask
endmodule // eior_ext_equip

// ===== bench/eior_router_tb.sv
// self-checking bench of the router: apb tasks, event and pin scenarios
// assumes eior_pkg compiled first and the outside equipment model
`timescale 1ns/100ps
module eior_router_tb;
  localparam int P = 16;
  localparam int HOLD = 1000;
  logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] pins;
  eior_pkg::eior_events_t evts;
  logic coaxOut, cyc, swp, ctl, prog, cycleTrigger, sweepLaunch, sourceOn, zeroOn;
  int failures, check_count, cycles, n, m, k;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  eior_router #(.PULSE_CYCLES(10'h010)) eior_router_inst (.clk(clk), .rst_b(rst_b),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coaxIn(pins[0]), .connCycleStartInput(pins[1]), .connSweepLaunchInput(pins[2]),
    .connInterlockInput(pins[3]), .connPinFiveInput(pins[4]), .instEvents(evts),
    .coaxOut(coaxOut), .connCycleTimingOutput(cyc), .connSweepTimingOutput(swp),
    .connControlStateOutput(ctl), .connProgOutput(prog), .cycleTrigger(cycleTrigger),
    .sweepLaunch(sweepLaunch), .sourceOn(sourceOn), .zeroOn(zeroOn));
  eior_ext_equip #(.W(HOLD)) eior_ext_equip_inst (.clk(clk), .pins(pins));
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // one instrument event, low cycles counted on coax and its pin
  task automatic fire(input int e);
    evts <= eior_pkg::eior_events_t'(8'h80 >> e);
    @(posedge clk);
    evts <= '0;
    n = 0;
    m = 0;
    repeat (3 * P) begin
      @(posedge clk);
      n += (coaxOut === 1'b0);
      m += ((e < 5 ? cyc : swp) === 1'b0);
    end
  endtask
  // outside pulse on pin i, start pulses counted
  task automatic stim(input int i);
    n = 0;
    m = 0;
    fork
      eior_ext_equip_inst.pulse(i);
      repeat (2 * P + 4) begin
        @(posedge clk);
        n += (cycleTrigger === 1'b1);
        m += (sweepLaunch === 1'b1);
      end
    join
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite} = 4'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    evts = '0;
    {failures, check_count, cycles} = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0, "route reset");
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'hFC, "status reset");
    check({coaxOut, cyc, swp, ctl, prog}, 32'h1F, "idle");
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1, "unmapped");
    for (k = 0; k < 8; k++) begin
      apb(1'b1, 8'h00, k < 5 ? (k << 6) | (k << 14) : 32'h10 | ((k - 5) << 9) | ((k - 5) << 17));
      fire(k);
      check(n, P, "coax width");
      check(m, P, "pin width");
      fire((k + 3) % 8);
      check(n, 0, "other event");
    end
    apb(1'b1, 8'h00, 32'h0);
    ce <= 1'b0;
    fire(0);
    ce <= 1'b1;
    check(n + m, 0, "frozen by enable");
    stim(0);
    check(n, 1, "coax trig");
    check(m, 0, "coax trig no sweep");
    stim(1);
    check(n, 1, "pin2 trig");
    apb(1'b1, 8'h00, 32'h1);
    stim(0);
    check(n, 0, "coax sweep no trig");
    check(m, 1, "coax sweep");
    apb(1'b1, 8'h00, 32'h80820);
    stim(4);
    check(sourceOn, 1'b1, "relay on");
    check({coaxOut, ctl}, 2'b00, "relay status");
    eior_ext_equip_inst.setPin(3, 1'b0);
    check(sourceOn, 1'b0, "interlock off");
    stim(4);
    check(sourceOn, 1'b0, "interlock hold");
    eior_ext_equip_inst.setPin(3, 1'b1);
    apb(1'b1, 8'h00, 32'h6);
    stim(0);
    check(sourceOn, 1'b1, "coax relay");
    apb(1'b1, 8'h00, 32'h103020);
    eior_ext_equip_inst.setPin(4, 1'b0);
    check({zeroOn, coaxOut, ctl}, 3'b100, "zero enter");
    eior_ext_equip_inst.setPin(4, 1'b1);
    check({zeroOn, sourceOn}, 2'b01, "zero leave");
    apb(1'b1, 8'h00, 32'h1820);
    apb(1'b1, 8'h04, 32'h0);
    @(posedge clk);
    check({coaxOut, prog}, 2'b00, "prog low");
    apb(1'b1, 8'h04, 32'h1);
    @(posedge clk);
    check({coaxOut, prog}, 2'b11, "prog high");
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h1, "prog level read");
    apb(1'b1, 8'h04, 32'h3);
    n = 0;
    m = 0;
    repeat (3 * P) begin
      @(posedge clk);
      n += (coaxOut === 1'b0);
      m += (prog === 1'b0);
    end
    check(n, P, "prog pulse coax");
    check(m, P, "prog pulse pin");
    results();
  end
endmodule // eior_router_tb
